/* File: hdl/ecpcr_top.sv */
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module ecpcr_top #(
    parameter longint WDOG_WINDOW_CYC = ecpcr_pkg::WDOG_WINDOW_CYC
) (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [9:0]              wb_adr_i,
    input  wire logic [31:0]             wb_dat_i,
    input  wire logic [3:0]              wb_sel_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    input  wire ecpcr_pkg::ecpcr_pcm_t   pcm_pins_in,
    input  wire ecpcr_pkg::ecpcr_pcm_t   pcm_core_out,
    input  wire logic                    ext_conv_off,
    input  wire logic [4:0]              ch_sel,
    output ecpcr_pkg::ecpcr_pcm_t        pcm_core_in,
    output ecpcr_pkg::ecpcr_pcm_t        pcm_pins_out,
    output ecpcr_pkg::ecpcr_outcfg_t     out_cfg,
    output ecpcr_pkg::ecpcr_chlaw_t      ch_law,
    output logic                         wdog_expired,
    output logic                         wdog_irq
);

    // ****************************************************
    // Functions
    // ****************************************************

    // Write strobe for one register index
    function automatic logic wr_hit(input logic wr, input logic [7:0] idx,
                                    input logic [7:0] want);
        return wr && (idx == want);
    endfunction

    // Law pick: conversion off forces the unconverted law on both ends
    function automatic logic pick_law(input logic conv_off, input logic unconv,
                                      input logic conv_law);
        return conv_off ? unconv : conv_law;
    endfunction

    // ****************************************************
    // Input synchronisers and channel store
    // ****************************************************
    ecpcr_pkg::ecpcr_pcm_t   pins_s;
    logic                    ext_off_s;
    ecpcr_pkg::ecpcr_chctl_t ch_rd;
    ecpcr_pkg::ecpcr_state_t s_ff;
    ecpcr_pkg::ecpcr_state_t nxt_s;
    logic [7:0]              idx;
    logic                    wr;
    logic                    ch_we;
    logic                    conv_eff;
    logic [31:0]             win_last;
    logic [16:0]             sync_q;

    ecpcr_sync #(.W(17)) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .d       ({pcm_pins_in, ext_conv_off}),
        .q       (sync_q)
    );
    // Split the synchronised word back into pin samples and the disable level
    assign pins_s    = sync_q[16:1];
    assign ext_off_s = sync_q[0];

    ecpcr_chmem u_chmem (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .we      (ch_we),
        .waddr   (idx[4:0]),
        .wdata   (wb_dat_i[7:0]),
        .raddr   (ch_sel),
        .rdata   (ch_rd)
    );

    // ****************************************************
    // Bus decode
    // ****************************************************

    // Write lands on the edge where the master sees ack
    assign idx      = wb_adr_i[9:2];
    assign wr       = s_ff.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
    assign ch_we    = wr && s_ff.wp_open && (idx >= ecpcr_pkg::IDX_CH_BASE)
                      && (idx <= ecpcr_pkg::IDX_CH_LAST);
    assign win_last = 32'(WDOG_WINDOW_CYC - 1);
    // Other sources count only when host-only control is off
    assign conv_eff = ch_rd.law_conversion_off
                      || (ext_off_s && !ch_rd.host_only_channel_control);

    // ****************************************************
    // Next-state logic
    // ****************************************************
    always_comb begin
        nxt_s = s_ff;

        // One-cycle ack; unmapped reads also answer zero
        nxt_s.ack = wb_cyc_i && wb_stb_i && !s_ff.ack;
        if (wb_cyc_i && wb_stb_i && !s_ff.ack) begin
            nxt_s.rdat = 8'h00;
            if (idx == ecpcr_pkg::IDX_STATUS) begin
                nxt_s.rdat = {5'h00, s_ff.wp_open, 1'b0, s_ff.wd_expired};
            end
        end

        // Protection key: anything but the key closes again
        if (wr_hit(wr, idx, ecpcr_pkg::IDX_WPROT)) begin
            nxt_s.wp_open = (wb_dat_i[7:0] == ecpcr_pkg::WP_KEY);
        end

        // Protected configuration writes; the interrupt mask is written even while locked
        if (s_ff.wp_open) begin
            if (wr_hit(wr, idx, ecpcr_pkg::IDX_LOOP)) begin
                nxt_s.loop = ecpcr_pkg::ecpcr_loop_t'({4'h0, wb_dat_i[3:0]});
            end
            if (wr_hit(wr, idx, ecpcr_pkg::IDX_OUTCFG)) begin
                nxt_s.outcfg = ecpcr_pkg::ecpcr_outcfg_t'(wb_dat_i[7:0]);
            end
            if (wr_hit(wr, idx, ecpcr_pkg::IDX_LAW)) begin
                nxt_s.law = ecpcr_pkg::ecpcr_law_t'({4'h0, wb_dat_i[3:0]});
            end
        end
        if (wr_hit(wr, idx, ecpcr_pkg::IDX_IRMASK)) begin
            nxt_s.irmask = wb_dat_i[6:0];
        end

        // Watchdog window counter runs from reset, the last good service or the last window lapse
        nxt_s.wd_cnt = s_ff.wd_cnt + 32'h0000_0001;
        case (s_ff.wd_st)
            ecpcr_pkg::WD_IDLE: begin
                if (wr_hit(wr, idx, ecpcr_pkg::IDX_WATCHDOG_KEY_FIRST)
                    && wb_dat_i[7:0] == ecpcr_pkg::WDG_KEY1) begin
                    nxt_s.wd_st = ecpcr_pkg::WD_KEY1;
                end
            end
            ecpcr_pkg::WD_KEY1: begin
                if (wr && idx >= ecpcr_pkg::IDX_WATCHDOG_KEY_FIRST && idx <= ecpcr_pkg::IDX_WATCHDOG_KEY_THIRD) begin
                    nxt_s.wd_st = (idx == ecpcr_pkg::IDX_WATCHDOG_KEY_SECOND
                                   && wb_dat_i[7:0] == ecpcr_pkg::WDG_KEY2)
                                  ? ecpcr_pkg::WD_KEY2 : ecpcr_pkg::WD_IDLE;
                end
            end
            ecpcr_pkg::WD_KEY2: begin
                if (wr && idx >= ecpcr_pkg::IDX_WATCHDOG_KEY_FIRST && idx <= ecpcr_pkg::IDX_WATCHDOG_KEY_THIRD) begin
                    nxt_s.wd_st = ecpcr_pkg::WD_IDLE;
                    if (idx == ecpcr_pkg::IDX_WATCHDOG_KEY_THIRD
                        && wb_dat_i[7:0] == ecpcr_pkg::WDG_KEY3) begin
                        nxt_s.wd_cnt     = 32'h0000_0000;
                        nxt_s.wd_expired = 1'b0;
                    end
                end
            end
            default: begin
                nxt_s.wd_st = ecpcr_pkg::WD_IDLE;
            end
        endcase

        // Late service: window lapses, sequence restarts; set beats clear
        if (s_ff.wd_cnt >= win_last) begin
            nxt_s.wd_cnt     = 32'h0000_0000;
            nxt_s.wd_st      = ecpcr_pkg::WD_IDLE;
            nxt_s.wd_expired = 1'b1;
        end
        nxt_s.wd_irq = nxt_s.wd_expired && !nxt_s.irmask[ecpcr_pkg::WDOG_MASK_BIT];

        // Loops and passthroughs; receive-to-send loop wins
        nxt_s.to_core.send_in = s_ff.loop.receive_to_send_loop
                                ? pcm_core_out.receive_in : pins_s.send_in;
        nxt_s.to_core.receive_in = (s_ff.loop.send_to_receive_loop
                                    && !s_ff.loop.receive_to_send_loop)
                                   ? pcm_core_out.send_in : pins_s.receive_in;
        nxt_s.to_pins.receive_in = s_ff.loop.receive_path_passthrough
                                   ? pins_s.receive_in : pcm_core_out.receive_in;
        nxt_s.to_pins.send_in = s_ff.loop.send_path_passthrough
                                ? pins_s.send_in : pcm_core_out.send_in;

        // Channel law resolution, one cycle behind the store read
        nxt_s.ch_d         = ch_sel;
        nxt_s.chlaw.chan   = s_ff.ch_d;
        nxt_s.chlaw.conv_off = conv_eff;
        if (s_ff.law.channel_individual_law) begin
            nxt_s.chlaw.near_alaw = pick_law(conv_eff, ch_rd.channel_law_when_unconverted,
                                             ch_rd.channel_near_end_alaw);
            nxt_s.chlaw.far_alaw  = pick_law(conv_eff, ch_rd.channel_law_when_unconverted,
                                             ch_rd.channel_far_end_alaw);
        end else begin
            nxt_s.chlaw.near_alaw = pick_law(conv_eff, s_ff.law.global_law_when_unconverted,
                                             s_ff.law.global_near_end_alaw);
            nxt_s.chlaw.far_alaw  = pick_law(conv_eff, s_ff.law.global_law_when_unconverted,
                                             s_ff.law.global_far_end_alaw);
        end
        // Attenuation follows each channel's canceller enable
        nxt_s.chlaw.send_atten_on    = s_ff.outcfg.send_atten_enable
                                       && !ch_rd.canceller_off;
        nxt_s.chlaw.receive_atten_on = s_ff.outcfg.receive_atten_enable
                                       && !ch_rd.canceller_off;
        nxt_s.chlaw.nlp_bypass       = ch_rd.nonlinear_proc_bypass;
        nxt_s.chlaw.freeze           = ch_rd.freeze;
        nxt_s.chlaw.canceller_off    = ch_rd.canceller_off;
    end

    // ****************************************************
    // State register
    // ****************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_ff            <= '0;
            s_ff.wd_st      <= ecpcr_pkg::WD_IDLE;
            s_ff.loop       <= ecpcr_pkg::ecpcr_loop_t'(ecpcr_pkg::RST_LOOP);
            s_ff.outcfg     <= ecpcr_pkg::ecpcr_outcfg_t'(ecpcr_pkg::RST_OUTCFG);
            s_ff.law        <= ecpcr_pkg::ecpcr_law_t'(ecpcr_pkg::RST_LAW);
            s_ff.irmask     <= ecpcr_pkg::RST_IRMASK;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from the state register; the core applies the
    // level, noise, subtractor and sign bits
    assign wb_dat_o     = {24'h00_0000, s_ff.rdat};
    assign wb_ack_o     = s_ff.ack;
    assign pcm_core_in  = s_ff.to_core;
    assign pcm_pins_out = s_ff.to_pins;
    assign out_cfg      = s_ff.outcfg;
    assign ch_law       = s_ff.chlaw;
    assign wdog_expired = s_ff.wd_expired;
    assign wdog_irq     = s_ff.wd_irq;

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_read_zero: assert property (wb_ack_o && !wb_we_i && idx != ecpcr_pkg::IDX_STATUS
                                  |-> wb_dat_o == 32'h0000_0000)
        else $error("write-only register returned data");
    a_wp_blocks: assert property (wr && !s_ff.wp_open && idx == ecpcr_pkg::IDX_OUTCFG
                                  |=> $stable(out_cfg))
        else $error("protected register written while locked");
    a_wp_key_open: assert property (wr && idx == ecpcr_pkg::IDX_WPROT
                                    |=> s_ff.wp_open == ($past(wb_dat_i[7:0])
                                                         == ecpcr_pkg::WP_KEY))
        else $error("protection key not honoured");
    a_wd_bad_key: assert property (s_ff.wd_st == ecpcr_pkg::WD_KEY1 && wr
                                   && idx == ecpcr_pkg::IDX_WATCHDOG_KEY_SECOND
                                   && wb_dat_i[7:0] != ecpcr_pkg::WDG_KEY2
                                   && s_ff.wd_cnt < win_last
                                   |=> s_ff.wd_st == ecpcr_pkg::WD_IDLE)
        else $error("bad watchdog key accepted");
    a_wd_late: assert property (s_ff.wd_cnt >= win_last
                                |=> wdog_expired && s_ff.wd_st == ecpcr_pkg::WD_IDLE)
        else $error("watchdog window lapse missed");
    a_wd_service: assert property (s_ff.wd_st == ecpcr_pkg::WD_KEY2 && wr
                                   && idx == ecpcr_pkg::IDX_WATCHDOG_KEY_THIRD
                                   && wb_dat_i[7:0] == ecpcr_pkg::WDG_KEY3
                                   && s_ff.wd_cnt < win_last
                                   |=> !wdog_expired && s_ff.wd_cnt == 32'h0)
        else $error("good service not taken");
    a_irq_mask: assert property (wdog_irq == (wdog_expired
                                 && !s_ff.irmask[ecpcr_pkg::WDOG_MASK_BIT]))
        else $error("watchdog interrupt gating wrong");
    a_loop_prio: assert property (s_ff.loop.send_to_receive_loop
                                  && s_ff.loop.receive_to_send_loop
                                  |=> pcm_core_in.receive_in == $past(pins_s.receive_in))
        else $error("send-to-receive loop active with both set");
    a_rcv_bypass: assert property (s_ff.loop.receive_path_passthrough
                                   |=> pcm_pins_out.receive_in
                                       == $past(pins_s.receive_in))
        else $error("receive passthrough broken");

    a_snd_bypass: assert property (s_ff.loop.send_path_passthrough
                                   |=> pcm_pins_out.send_in
                                       == $past(pins_s.send_in))
        else $error("send passthrough broken");

    a_rs_loop: assert property (s_ff.loop.receive_to_send_loop
                                |=> pcm_core_in.send_in
                                    == $past(pcm_core_out.receive_in))
        else $error("receive-to-send loop broken");

    a_sr_loop: assert property (s_ff.loop.send_to_receive_loop && !s_ff.loop.receive_to_send_loop
                                |=> pcm_core_in.receive_in
                                    == $past(pcm_core_out.send_in))
        else $error("send-to-receive loop broken");

    a_ch_tag: assert property (1'b1 |=> ##1 ch_law.chan == $past(ch_sel, 2))
        else $error("channel tag out of step");
    a_law_global: assert property (!s_ff.law.channel_individual_law && !conv_eff
                                   && $stable(s_ff.law)
                                   |=> ch_law.near_alaw
                                       == $past(s_ff.law.global_near_end_alaw))
        else $error("global near-end law wrong");

    c_wd_served: cover property (s_ff.wd_st == ecpcr_pkg::WD_KEY2
                                 ##1 s_ff.wd_st == ecpcr_pkg::WD_IDLE && !wdog_expired);
    c_wd_late:   cover property (s_ff.wd_cnt >= win_last);
    c_wp_open:   cover property (!s_ff.wp_open ##1 s_ff.wp_open);
    c_both_loop: cover property (s_ff.loop.send_to_receive_loop
                                 && s_ff.loop.receive_to_send_loop);
    // Disable level present but masked by host-only control
    c_host_only: cover property (ext_off_s && ch_rd.host_only_channel_control);

endmodule // ecpcr_top

`default_nettype wire

/* File: pkg/ecpcr_pkg.sv */
package ecpcr_pkg;

    // ****************************************************
    // Register map (word index, byte address = 4 * index)
    // ****************************************************
    localparam logic [7:0] IDX_WPROT   = 8'h01;
    localparam logic [7:0] IDX_WATCHDOG_KEY_FIRST    = 8'h02;
    localparam logic [7:0] IDX_WATCHDOG_KEY_SECOND    = 8'h03;
    localparam logic [7:0] IDX_WATCHDOG_KEY_THIRD    = 8'h04;
    localparam logic [7:0] IDX_LOOP    = 8'h06;
    localparam logic [7:0] IDX_IRMASK  = 8'h07;
    localparam logic [7:0] IDX_STATUS  = 8'h08;
    localparam logic [7:0] IDX_OUTCFG  = 8'h30;
    localparam logic [7:0] IDX_LAW     = 8'h3f;
    localparam logic [7:0] IDX_CH_BASE = 8'h40;
    localparam logic [7:0] IDX_CH_LAST = 8'h5f;

    // ****************************************************
    // Key values and reset values
    // ****************************************************
    localparam logic [7:0] WP_KEY       = 8'h95;
    localparam logic [7:0] WDG_KEY1     = 8'haa;
    localparam logic [7:0] WDG_KEY2     = 8'h99;
    localparam logic [7:0] WDG_KEY3     = 8'h1d;
    localparam logic [7:0] RST_LOOP     = 8'h00;
    localparam logic [7:0] RST_OUTCFG   = 8'h03;
    localparam logic [7:0] RST_LAW      = 8'h00;
    localparam logic [7:0] RST_CHCTL    = 8'h00;
    localparam logic [6:0] RST_IRMASK   = 7'h7f;
    localparam int         WDOG_MASK_BIT = 6;
    localparam int         NUM_CH       = 32;
    localparam int         CH_W         = 5;

    // ****************************************************
    // Timing
    // ****************************************************
    localparam longint CLK_HZ          = 200_000_000;
    localparam longint WDOG_WINDOW_S   = 2;
    localparam longint WDOG_WINDOW_CYC = WDOG_WINDOW_S * CLK_HZ;

    // ****************************************************
    // Field layouts
    // ****************************************************
    typedef struct packed {
        logic [3:0] rsvd;
        logic       send_to_receive_loop;
        logic       receive_to_send_loop;
        logic       receive_path_passthrough;
        logic       send_path_passthrough;
    } ecpcr_loop_t;

    typedef struct packed {
        logic itu_comfort_noise;
        logic nonlinear_proc_output_mode;
        logic send_atten_enable;
        logic send_atten_level;
        logic receive_atten_enable;
        logic receive_atten_level;
        logic dynamic_subtractor;
        logic error_sign_invert;
    } ecpcr_outcfg_t;

    typedef struct packed {
        logic [3:0] rsvd;
        logic       channel_individual_law;
        logic       global_law_when_unconverted;
        logic       global_near_end_alaw;
        logic       global_far_end_alaw;
    } ecpcr_law_t;

    typedef struct packed {
        logic channel_law_when_unconverted;
        logic channel_near_end_alaw;
        logic channel_far_end_alaw;
        logic law_conversion_off;
        logic freeze;
        logic nonlinear_proc_bypass;
        logic canceller_off;
        logic host_only_channel_control;
    } ecpcr_chctl_t;

    // Per-channel result handed to the processing core
    typedef struct packed {
        logic [4:0] chan;
        logic       near_alaw;
        logic       far_alaw;
        logic       conv_off;
        logic       send_atten_on;
        logic       receive_atten_on;
        logic       nlp_bypass;
        logic       freeze;
        logic       canceller_off;
    } ecpcr_chlaw_t;

    typedef struct packed {
        logic [7:0] receive_in;
        logic [7:0] send_in;
    } ecpcr_pcm_t;

    typedef enum logic [1:0] {
        WD_IDLE,
        WD_KEY1,
        WD_KEY2
    } ecpcr_wd_t;

    typedef struct packed {
        logic          ack;
        logic [7:0]    rdat;
        logic          wp_open;
        ecpcr_loop_t   loop;
        ecpcr_outcfg_t outcfg;
        ecpcr_law_t    law;
        logic [6:0]    irmask;
        ecpcr_wd_t     wd_st;
        logic [31:0]   wd_cnt;
        logic          wd_expired;
        logic          wd_irq;
        logic [4:0]    ch_d;
        ecpcr_chlaw_t  chlaw;
        ecpcr_pcm_t    to_core;
        ecpcr_pcm_t    to_pins;
    } ecpcr_state_t;

endpackage

/* File: hdl/ecpcr_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for pin-side levels
module ecpcr_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_ff;

    // First stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end

endmodule // ecpcr_sync

`default_nettype wire

/* File: hdl/ecpcr_chmem.sv */
`timescale 1ns/1ps
`default_nettype none

// Per-channel control store, registered read
module ecpcr_chmem (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic                   we,
    input  wire logic [4:0]             waddr,
    input  wire logic [7:0]             wdata,
    input  wire logic [4:0]             raddr,
    output ecpcr_pkg::ecpcr_chctl_t     rdata
);

    logic [7:0] mem_ff [ecpcr_pkg::NUM_CH];

    // Every channel clears to its reset value
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < ecpcr_pkg::NUM_CH; i++) begin
                mem_ff[i] <= ecpcr_pkg::RST_CHCTL;
            end
            rdata <= ecpcr_pkg::ecpcr_chctl_t'(ecpcr_pkg::RST_CHCTL);
        end else begin
            if (we) begin
                mem_ff[waddr] <= wdata;
            end
            rdata <= ecpcr_pkg::ecpcr_chctl_t'(mem_ff[raddr]);
        end
    end

endmodule // ecpcr_chmem

`default_nettype wire

/* File: bench/ecpcr_pcm_far.sv */
`timescale 1ns/1ps
`default_nettype none

// Far-end highway model: presents the requested pattern, pat[15:8] on receive_in and pat[7:0] on send_in
module ecpcr_pcm_far (
    input  wire logic             sys_clk,
    input  wire logic [15:0]      pat,
    output ecpcr_pkg::ecpcr_pcm_t pins
);
    // Samples change just after an edge, as a framed source would
    always @(posedge sys_clk) begin
        pins <= pat;
    end
endmodule // ecpcr_pcm_far

`default_nettype wire

/* File: bench/tb_echo_canceller_pcm_config_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_echo_canceller_pcm_config_regs;
    // ****************************************************
    // Stimulus, notes queue and output watcher
    // ****************************************************
    logic                     sys_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, look = 0;
    logic [9:0]               adr = '0;
    logic [31:0]              dat = '0, dat_o;
    logic [2:0]               kind = '0;
    logic                     ext_off = 0;
    logic [4:0]               ch_sel = '0, c;
    logic [7:0]               d;
    logic [15:0]              pat = '0;
    logic                     ack, wexp, wirq;
    logic [18:0]              n, notes[$];
    logic [18:0]              lt[4] = '{{8'h06, 8'h00, 3'b100}, {8'h04, 8'h10, 3'b111},
                                        {8'h08, 8'hc0, 3'b100}, {8'h08, 8'h90, 3'b111}};
    ecpcr_pkg::ecpcr_pcm_t    pins, core_out = '0, core_in, pins_out;
    ecpcr_pkg::ecpcr_outcfg_t cfg;
    ecpcr_pkg::ecpcr_chlaw_t  law;
    int                       errors = 0, tests_run = 0;

    initial forever #2.5 sys_clk = ~sys_clk;

    ecpcr_pcm_far u_far (.sys_clk(sys_clk), .pat(pat), .pins(pins));

    // Short window keeps the watchdog lapse inside a quick run
    ecpcr_top #(.WDOG_WINDOW_CYC(200)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .pcm_pins_in(pins), .pcm_core_out(core_out), .ext_conv_off(ext_off), .ch_sel(ch_sel),
        .pcm_core_in(core_in), .pcm_pins_out(pins_out), .out_cfg(cfg), .ch_law(law),
        .wdog_expired(wexp), .wdog_irq(wirq));

    task check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            errors++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task conclude;
        $display("tests_run=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Classic cycle: hold everything until ack is sampled, then release
    task wb(input logic [7:0] idx, input logic [7:0] v, input logic w);
        @(posedge sys_clk);
        cyc <= 1; stb <= 1; we <= w; adr <= {idx, 2'b00}; dat <= {24'h0, v};
        @(posedge sys_clk iff ack);
        cyc <= 0; stb <= 0; we <= 0;
    endtask

    // Kind 0 waits for read data; other kinds raise a look strobe
    task note(input logic [2:0] k, input logic [15:0] e);
        notes.push_back({k, e});
        if (k != 3'd0) begin
            @(posedge sys_clk); look <= 1; kind <= k;
            @(posedge sys_clk); look <= 0;
        end
    endtask

    task rd(input logic [7:0] idx, input logic [15:0] e);
        note(3'd0, e);
        wb(idx, 8'h00, 0);
    endtask

    task pcm(input logic [7:0] v, input logic [2:0] k, input logic [15:0] e);
        wb(8'h06, v, 1);
        repeat (5) @(posedge sys_clk);
        note(k, e);
    endtask

    function automatic logic [15:0] obs(input logic [2:0] k);
        case (k)
            3'd0: obs = dat_o[15:0];
            3'd1: obs = {8'h00, cfg};
            3'd2: obs = {8'h00, law.chan, law.near_alaw, law.far_alaw, law.conv_off};
            3'd3: obs = {14'h0, wexp, wirq};
            3'd4: obs = core_in;
            default: obs = pins_out;
        endcase
    endfunction

    // Oldest note is matched against whatever result shows up
    always @(posedge sys_clk) begin
        if ((ack && !we) || look) begin
            if (notes.size() == 0) errors++;
            else begin
                n = notes.pop_front();
                check(obs(n[18:16]), n[15:0]);
            end
        end
    end

    initial begin
        void'($urandom(10));
        repeat (6) @(posedge sys_clk);
        rst_n <= 1;
        note(3'd1, 16'h0003);
        note(3'd2, 16'h0000);
        $display("reset test done");
        repeat (210) @(posedge sys_clk);
        note(3'd3, 16'h0002);
        wb(8'h07, 8'h00, 1);
        note(3'd3, 16'h0003);
        wb(8'h02, 8'haa, 1); wb(8'h04, 8'h1d, 1); wb(8'h03, 8'h99, 1); wb(8'h04, 8'h1d, 1);
        note(3'd3, 16'h0003);
        wb(8'h02, 8'haa, 1); wb(8'h03, 8'h99, 1); wb(8'h04, 8'h1d, 1);
        note(3'd3, 16'h0000);
        $display("watchdog test done");
        d = 8'($urandom);
        wb(8'h30, d, 1);
        note(3'd1, 16'h0003);
        wb(8'h01, 8'h95, 1); wb(8'h30, d, 1);
        note(3'd1, {8'h00, d});
        rd(8'h30, 16'h0000);
        rd(8'h20, 16'h0000);
        wb(8'h01, 8'h00, 1); wb(8'h30, ~d, 1);
        note(3'd1, {8'h00, d});
        wb(8'h01, 8'h95, 1);
        rd(8'h08, 16'h0004);
        $display("protection test done");
        c = 5'($urandom);
        ch_sel <= c;
        for (int i = 0; i < 4; i++) begin
            wb(8'h3f, lt[i][18:11], 1); wb(8'h40 + 8'(c), lt[i][10:3], 1);
            repeat (3) @(posedge sys_clk);
            note(3'd2, {8'h00, c, lt[i][2:0]});
        end
        // Outside disable source, then the same channel under host-only control
        ext_off <= 1;
        wb(8'h40 + 8'(c), 8'hc0, 1);
        repeat (5) @(posedge sys_clk);
        note(3'd2, {8'h00, c, 3'b111});
        wb(8'h40 + 8'(c), 8'hc1, 1);
        repeat (3) @(posedge sys_clk);
        note(3'd2, {8'h00, c, 3'b100});
        ext_off <= 0;
        $display("law test done");
        pat <= 16'($urandom); core_out <= 16'($urandom);
        @(posedge sys_clk);
        pcm(8'h03, 3'd5, pat);
        pcm(8'h04, 3'd4, {pat[15:8], core_out.receive_in});
        pcm(8'h08, 3'd4, {core_out.send_in, pat[7:0]});
        pcm(8'h0c, 3'd4, {pat[15:8], core_out.receive_in});
        $display("pcm test done");
        conclude();
    end

    // Hang guard, well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        conclude();
    end
endmodule // tb_echo_canceller_pcm_config_regs

`default_nettype wire
